/* hw/alarm_indicator_params.svh */
/*
  Constants of the system alarm indicator: alarm codes, LED patterns,
  offset limit and timing counts.
  Assumes it is included by bare name from the modules and the test bench.
*/
`ifndef ALARM_INDICATOR_PARAMS_SVH
`define ALARM_INDICATOR_PARAMS_SVH

// ----------------------------------------------------------------------
// Alarm codes, binary value of the decimal alarm number
// ----------------------------------------------------------------------
`define CODE_NONE        10'h000
`define CODE_WDT         10'h398
`define CODE_RAM_PARITY  10'h38F
`define CODE_UNUSED_IRQ  10'h3A2
`define CODE_OFFSET      10'h3AC
`define CODE_ADD_RAM     10'h3E4
`define CODE_ROM_PC      10'h3E5
`define CODE_ROM_BASIC   10'h3E6
`define CODE_ROM_PAIR    10'h3E7
`define CODE_SYS_LOW     10'h384
`define CODE_SYS_EXCL    10'h38E

// ----------------------------------------------------------------------
// Status LED patterns, bit 3 down to bit 0, one means lit
// ----------------------------------------------------------------------
`define LED_NORMAL       4'h0
`define LED_SLAVE_OFF    4'h1
`define LED_SYS_ALARM    4'h2
`define LED_RAM_PARITY   4'h4
`define LED_ALL_ON       4'hF

// ----------------------------------------------------------------------
// Offset limit in micrometres, 999.999 mm
// ----------------------------------------------------------------------
`define OFFSET_LIMIT_UM  32'h000F423F

// ----------------------------------------------------------------------
// Timing: clock rate, flicker half period and power-on settle count
// ----------------------------------------------------------------------
`define CLK_KHZ          40000
`define FLICKER_HALF_MS  250
`define PWR_SETTLE       2'h3

`endif

/* hw/alarm_indicator_pkg.sv */
/*
  Types of the system alarm indicator.
  Assumes nothing beyond the parameter header.
*/
package alarm_indicator_pkg;

  // Sticky alarm sources
  typedef struct packed {
    logic wdt;
    logic unused_irq;
    logic ram_parity;
    logic rom_pc;
    logic rom_basic;
    logic rom_pair;
    logic add_ram;
    logic offset;
  } alarm_flags_type;

  // Whole state of the top module
  typedef struct packed {
    alarm_flags_type flags;
    logic [9:0]      code;
    logic            active;
    logic [3:0]      rom_idx;
    logic            ram_fail;
    logic [2:0]      ram_num;
    logic [3:0]      led;
    logic            lamp;
    logic [2:0]      key_s1;
    logic [2:0]      key_s2;
    logic [1:0]      pwr_cnt;
    logic            pwr_done;
    logic            param_clear;
  } alarm_state_type;

  // Whole state of the flicker timer
  typedef struct packed {
    logic [23:0] count;
    logic        phase;
  } flicker_state_type;

endpackage

/* hw/flicker_timer.sv */
/*
  Free running flicker source for the status LEDs.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`include "alarm_indicator_params.svh"

module flicker_timer #(
  parameter int HALF_CYC = `FLICKER_HALF_MS * `CLK_KHZ
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      blink_o
);

  alarm_indicator_pkg::flicker_state_type s_q;
  alarm_indicator_pkg::flicker_state_type s_d;

  // ----------------------------------------------------------------------
  // Counter toggles the phase every half period
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.count >= 24'(HALF_CYC - 1)) begin
      s_d.count = 24'h000000;
      s_d.phase = ~s_q.phase;
    end else begin
      s_d.count = s_q.count + 24'h000001;
    end
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign blink_o = s_q.phase;

  chk_phase_period: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_q.count != 24'(HALF_CYC - 1)) |=> $stable(s_q.phase))
    else $error("Flicker phase changed before the half period ended");

endmodule // flicker_timer

/* hw/system_alarm_indicator.sv */
/*
  System alarm indicator: latches fault events into alarm codes, drives the
  watchdog lamp and four status LEDs, and detects the power-on clear request.
  Assumes fault inputs come from logic on MCLK_I; switch and keys are pins.
*/
// Overview of operation
// - Watchdog expiry: code 920, watchdog lamp on
// - Unused interrupt raises processor error 930
// - Offset beyond 999.999 mm raises 940
// - Main RAM parity failure raises 911
// - Needed additional RAM missing raises 996
// - ROM faults 997/998/999 with failing ROM index
// - Four status LEDs mirror alarm content
// - Alarms 900-999 except 910/911: LED1 only
// - RAM parity alarm: LED2 only
// - RAM test failure: LED3 plus RAM number
// - LEDs flicker during RAM test wait/end
`timescale 1ns/1ps
`include "alarm_indicator_params.svh"

module system_alarm_indicator #(
  parameter int FLICKER_HALF_CYC = `FLICKER_HALF_MS * `CLK_KHZ
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  input  wire logic        WDT_EXPIRED_I,
  input  wire logic        UNUSED_IRQ_I,
  input  wire logic        OFFSET_VALID_I,
  input  wire logic [31:0] OFFSET_VALUE_I,
  input  wire logic        RAM_PARITY_ERR_I,
  input  wire logic        ADD_RAM_OPTION_I,
  input  wire logic        ADD_RAM_OK_I,
  input  wire logic        ROM_PC_PARITY_I,
  input  wire logic        ROM_BASIC_PARITY_I,
  input  wire logic        ROM_PAIR_ERR_I,
  input  wire logic [3:0]  ROM_INDEX_I,
  input  wire logic        SLAVE_READY_I,
  input  wire logic        RAM_TEST_WAIT_I,
  input  wire logic        RAM_TEST_END_I,
  input  wire logic        RAM_TEST_FAIL_I,
  input  wire logic [2:0]  RAM_TEST_NUM_I,
  input  wire logic        ALARM_CLEAR_I,
  input  wire logic        PARAM_WRITE_EN_I,
  input  wire logic        CANCEL_KEY_I,
  input  wire logic        DELETE_KEY_I,
  output logic             ALARM_ACTIVE_O,
  output logic [9:0]       ALARM_CODE_O,
  output logic [3:0]       ROM_INDEX_O,
  output logic             WATCHDOG_ALARM_LAMP_O,
  output logic [3:0]       STATUS_LED_O,
  output logic             PARAM_CLEAR_O
);

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  alarm_indicator_pkg::alarm_state_type s_q;
  alarm_indicator_pkg::alarm_state_type s_d;
  alarm_indicator_pkg::alarm_flags_type ev;
  logic                                 blink;
  logic                                 offset_bad;
  logic                                 rom_ev;

  // ----------------------------------------------------------------------
  // Flicker source
  // ----------------------------------------------------------------------
  flicker_timer #(
    .HALF_CYC (FLICKER_HALF_CYC)
  ) u_flicker (
    .clk_i   (MCLK_I),
    .reset_i (RESET_I),
    .blink_o (blink)
  );

  // ----------------------------------------------------------------------
  // Fault events of this cycle
  // ----------------------------------------------------------------------
  // Signed compare in micrometres so that both signs are caught
  assign offset_bad = OFFSET_VALID_I &&
                      (($signed(OFFSET_VALUE_I) > $signed(`OFFSET_LIMIT_UM)) ||
                       ($signed(OFFSET_VALUE_I) < -$signed(`OFFSET_LIMIT_UM)));
  assign rom_ev     = ROM_PC_PARITY_I | ROM_BASIC_PARITY_I | ROM_PAIR_ERR_I;

  always_comb begin
    ev            = '0;
    ev.wdt        = WDT_EXPIRED_I;
    ev.unused_irq = UNUSED_IRQ_I;
    ev.ram_parity = RAM_PARITY_ERR_I;
    ev.rom_pc     = ROM_PC_PARITY_I;
    ev.rom_basic  = ROM_BASIC_PARITY_I;
    ev.rom_pair   = ROM_PAIR_ERR_I;
    ev.add_ram    = ADD_RAM_OPTION_I & ~ADD_RAM_OK_I;
    ev.offset     = offset_bad;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Sticky flags: an event in the clear cycle survives the clear
    s_d.flags = (ALARM_CLEAR_I ? '0 : s_q.flags) | ev;
    if (ALARM_CLEAR_I) begin
      s_d.active   = 1'b0;
      s_d.code     = `CODE_NONE;
      s_d.rom_idx  = 4'h0;
      s_d.ram_fail = 1'b0;
      s_d.ram_num  = 3'h0;
    end

    // First alarm latches its code; later ones are ignored until a clear
    if (!s_d.active) begin
      s_d.active = 1'b1;
      if (s_d.flags.wdt) begin
        s_d.code = `CODE_WDT;
      end else if (s_d.flags.unused_irq) begin
        s_d.code = `CODE_UNUSED_IRQ;
      end else if (s_d.flags.ram_parity) begin
        s_d.code = `CODE_RAM_PARITY;
      end else if (s_d.flags.rom_pair) begin
        s_d.code = `CODE_ROM_PAIR;
      end else if (s_d.flags.rom_basic) begin
        s_d.code = `CODE_ROM_BASIC;
      end else if (s_d.flags.rom_pc) begin
        s_d.code = `CODE_ROM_PC;
      end else if (s_d.flags.add_ram) begin
        s_d.code = `CODE_ADD_RAM;
      end else if (s_d.flags.offset) begin
        s_d.code = `CODE_OFFSET;
      end else begin
        s_d.active = 1'b0;
      end
    end

    // ROM index kept from the first ROM fault after a clear
    if (rom_ev && !(s_q.flags.rom_pc | s_q.flags.rom_basic | s_q.flags.rom_pair)) begin
      s_d.rom_idx = ROM_INDEX_I;
    end else if (rom_ev && ALARM_CLEAR_I) begin
      s_d.rom_idx = ROM_INDEX_I;
    end

    // RAM test result is sticky, first failing RAM kept
    if (RAM_TEST_FAIL_I && (!s_q.ram_fail || ALARM_CLEAR_I)) begin
      s_d.ram_fail = 1'b1;
      s_d.ram_num  = RAM_TEST_NUM_I;
    end

    s_d.lamp = s_d.flags.wdt;

    // LED priority: test fail, test flicker, parity, 9xx, slave ready
    if (s_d.ram_fail) begin
      s_d.led = {1'b1, s_d.ram_num};
    end else if (RAM_TEST_WAIT_I || RAM_TEST_END_I) begin
      s_d.led = blink ? `LED_ALL_ON : `LED_NORMAL;
    end else if (s_d.flags.ram_parity) begin
      s_d.led = `LED_RAM_PARITY;
    end else if (s_d.active && s_d.code >= `CODE_SYS_LOW &&
                 s_d.code != `CODE_SYS_EXCL && s_d.code != `CODE_RAM_PARITY) begin
      s_d.led = `LED_SYS_ALARM;
    end else if (!SLAVE_READY_I) begin
      s_d.led = `LED_SLAVE_OFF;
    end else begin
      s_d.led = `LED_NORMAL;
    end

    // Pins pass two flops; stage one feeds only stage two
    s_d.key_s1 = {PARAM_WRITE_EN_I, CANCEL_KEY_I, DELETE_KEY_I};
    s_d.key_s2 = s_q.key_s1;

    // Power-on clear is sampled once, after the synchroniser has filled
    s_d.param_clear = 1'b0;
    if (!s_q.pwr_done) begin
      if (s_q.pwr_cnt == `PWR_SETTLE) begin
        s_d.pwr_done    = 1'b1;
        s_d.param_clear = &s_q.key_s2;
      end else begin
        s_d.pwr_cnt = s_q.pwr_cnt + 2'h1;
      end
    end
  end

  // Register the state
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------------
  assign ALARM_ACTIVE_O        = s_q.active;
  assign ALARM_CODE_O          = s_q.code;
  assign ROM_INDEX_O           = s_q.rom_idx;
  assign WATCHDOG_ALARM_LAMP_O = s_q.lamp;
  assign STATUS_LED_O          = s_q.led;
  assign PARAM_CLEAR_O         = s_q.param_clear;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_wdt_code_lamp: assert property (
    (WDT_EXPIRED_I && !ALARM_ACTIVE_O) |=> (ALARM_CODE_O == `CODE_WDT) && WATCHDOG_ALARM_LAMP_O)
    else $error("Watchdog expiry did not give code 920 and lamp");

  chk_unused_irq_code: assert property (
    (UNUSED_IRQ_I && !WDT_EXPIRED_I && !ALARM_ACTIVE_O) |=> ALARM_CODE_O == `CODE_UNUSED_IRQ)
    else $error("Unused interrupt did not give code 930");

  chk_offset_range: assert property (
    (OFFSET_VALID_I && $signed(OFFSET_VALUE_I) == -$signed(`OFFSET_LIMIT_UM) - 1)
      |=> s_q.flags.offset)
    else $error("Offset just beyond the limit was not flagged");

  chk_ram_parity_led: assert property (
    (RAM_PARITY_ERR_I && !RAM_TEST_FAIL_I && !s_q.ram_fail && !RAM_TEST_WAIT_I
      && !RAM_TEST_END_I) |=> STATUS_LED_O == `LED_RAM_PARITY)
    else $error("RAM parity did not light LED 2 alone");

  chk_add_ram_flag: assert property (
    (ADD_RAM_OPTION_I && !ADD_RAM_OK_I) |=> s_q.flags.add_ram ##0 ALARM_ACTIVE_O)
    else $error("Missing additional RAM not flagged");

  chk_rom_index_kept: assert property (
    (rom_ev && !ALARM_CLEAR_I && (s_q.flags.rom_pc | s_q.flags.rom_basic | s_q.flags.rom_pair))
      |=> $stable(ROM_INDEX_O))
    else $error("ROM index changed without a clear");

  chk_ram_test_led: assert property (
    (RAM_TEST_FAIL_I && !s_q.ram_fail) |=> STATUS_LED_O == {1'b1, $past(RAM_TEST_NUM_I)})
    else $error("RAM test failure LED code wrong");

  chk_flicker_pattern: assert property (
    (RAM_TEST_WAIT_I && !RAM_TEST_FAIL_I && !s_q.ram_fail)
      |=> (STATUS_LED_O == `LED_ALL_ON) || (STATUS_LED_O == `LED_NORMAL))
    else $error("LEDs not flickering during RAM test wait");

  chk_slave_led: assert property (
    (STATUS_LED_O == `LED_SLAVE_OFF) |-> !ALARM_ACTIVE_O && !s_q.ram_fail)
    else $error("Slave ready LED shown while an alarm is held");

  chk_code_hold: assert property (
    (ALARM_ACTIVE_O && !ALARM_CLEAR_I) |=> $stable(ALARM_CODE_O) && ALARM_ACTIVE_O)
    else $error("Latched alarm code changed without clear");

  chk_param_pulse: assert property (
    PARAM_CLEAR_O |=> !PARAM_CLEAR_O [*3])
    else $error("Parameter clear pulse repeated");

endmodule // system_alarm_indicator

/* test/system_alarm_indicator_test.sv */
/*
  Self-checking bench of the system alarm indicator: random fault sets,
  offset bounds, LED patterns, flicker and the power-on clear request.
  Assumes the design and its parameter header are compiled before it.
*/
`timescale 1ns/1ps
`include "alarm_indicator_params.svh"

module system_alarm_indicator_test;
  // ------------------------------------------------------------------
  // Stimulus, observed outputs and counters
  // ------------------------------------------------------------------
  localparam int HALF = 4;  // Short flicker half period keeps the run brief
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wdt = 1'b0, irq = 1'b0, off_v = 1'b0, par = 1'b0, opt = 1'b0;
  logic        ok = 1'b1, pc = 1'b0, basic = 1'b0, pair = 1'b0, slv = 1'b1;
  logic        wait_t = 1'b0, end_t = 1'b0, fail_t = 1'b0, clr = 1'b0;
  logic        sw = 1'b0, cancel_key = 1'b0, delete_key = 1'b0;
  logic [31:0] off_val = 32'h0;
  logic [3:0]  rom_i = 4'h0;
  logic [2:0]  num = 3'h0;
  logic        act, watchdog_alarm_lamp, pclr;
  logic [9:0]  code;
  logic [3:0]  rom_o, led;
  int          err_total = 0, cmp_count = 0, cyc = 0;

  system_alarm_indicator #(.FLICKER_HALF_CYC(HALF)) dut (
    .MCLK_I(mclk), .RESET_I(rst), .WDT_EXPIRED_I(wdt), .UNUSED_IRQ_I(irq),
    .OFFSET_VALID_I(off_v), .OFFSET_VALUE_I(off_val), .RAM_PARITY_ERR_I(par),
    .ADD_RAM_OPTION_I(opt), .ADD_RAM_OK_I(ok), .ROM_PC_PARITY_I(pc),
    .ROM_BASIC_PARITY_I(basic), .ROM_PAIR_ERR_I(pair), .ROM_INDEX_I(rom_i),
    .SLAVE_READY_I(slv), .RAM_TEST_WAIT_I(wait_t), .RAM_TEST_END_I(end_t),
    .RAM_TEST_FAIL_I(fail_t), .RAM_TEST_NUM_I(num), .ALARM_CLEAR_I(clr),
    .PARAM_WRITE_EN_I(sw), .CANCEL_KEY_I(cancel_key), .DELETE_KEY_I(delete_key),
    .ALARM_ACTIVE_O(act), .ALARM_CODE_O(code), .ROM_INDEX_O(rom_o),
    .WATCHDOG_ALARM_LAMP_O(watchdog_alarm_lamp), .STATUS_LED_O(led),
    .PARAM_CLEAR_O(pclr));

  // Clock and hang guard; the whole run needs well under 3000 cycles
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Winning code of a fault set, bit order is the latch priority
  function automatic logic [9:0] exp_code(input logic [7:0] m);
    logic [9:0] t [8];
    t = '{`CODE_WDT, `CODE_UNUSED_IRQ, `CODE_RAM_PARITY, `CODE_ROM_PAIR,
          `CODE_ROM_BASIC, `CODE_ROM_PC, `CODE_ADD_RAM, `CODE_OFFSET};
    for (int i = 0; i < 8; i++) if (m[i]) return t[i];
    return `CODE_NONE;
  endfunction

  // One-cycle fault set, optionally with a clear in the same cycle
  task automatic fire(input logic [7:0] m, input logic [3:0] ri, input logic c);
    @(posedge mclk);
    {pair, basic, pc, par, irq, wdt} <= {m[3], m[4], m[5], m[2], m[1], m[0]};
    opt <= m[6];
    ok <= !m[6];
    off_v <= m[7];
    off_val <= 32'h000F4240;  // One micrometre past the limit
    rom_i <= ri;
    clr <= c;
    @(posedge mclk);
    {wdt, irq, par, pair, basic, pc, opt, off_v, clr} <= '0;
    ok <= 1'b1;
    @(negedge mclk);
  endtask

  task automatic check_latched(input logic [7:0] m, input logic [3:0] ri);
    chk("code", exp_code(m), code);
    chk("active", 32'h1, act);
    chk("lamp", m[0], watchdog_alarm_lamp);
    chk("led", m[2] ? `LED_RAM_PARITY : `LED_SYS_ALARM, led);
    if (|m[5:3]) chk("rom index", ri, rom_o);
  endtask

  task automatic clear_all(input logic [3:0] exp_led);
    fire(8'h00, 4'h0, 1'b1);
    chk("cleared code", `CODE_NONE, code);
    chk("cleared lamp", 32'h0, watchdog_alarm_lamp);
    chk("cleared led", exp_led, led);
  endtask

  // Reset with switch k[1] and both keys k[0], then count clear pulses
  task automatic do_reset(input logic [1:0] k);
    int n;
    n = 0;
    @(posedge mclk);
    rst <= 1'b1;
    sw <= k[1];
    cancel_key <= k[0];
    delete_key <= k[0];
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("reset outputs", 32'h0, {act, code, watchdog_alarm_lamp, led, pclr});
    repeat (12) begin
      @(negedge mclk);
      n += pclr;
    end
    chk("clear pulses", (k == 2'b11), n);
  endtask

  task automatic off_try(input int v);
    int a;
    a = (v < 0) ? -v : v;
    @(posedge mclk);
    off_v <= 1'b1;
    off_val <= v;
    @(posedge mclk);
    off_v <= 1'b0;
    @(negedge mclk);
    chk("offset code", (a > `OFFSET_LIMIT_UM) ? `CODE_OFFSET : `CODE_NONE, code);
    clear_all(`LED_NORMAL);
  endtask

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int on, off, other;
    logic [7:0] m;
    logic [3:0] ri;
    void'($urandom(6));
    for (int k = 0; k < 4; k++) do_reset(k[1:0]);
    @(posedge mclk);
    cancel_key <= 1'b0;
    delete_key <= 1'b0;
    $display("test power-on clear done");
    // Every fault alone, then random sets that stress the priority
    for (int i = 0; i < 40; i++) begin
      m = (i < 8) ? (8'h01 << i) : 8'($urandom_range(1, 255));
      ri = 4'($urandom_range(0, 15));
      fire(m, ri, 1'b0);
      check_latched(m, ri);
      clear_all(`LED_NORMAL);
    end
    // Later fault must not replace the first; set beats a same-cycle clear
    fire(8'h01, 4'h0, 1'b0);
    fire(8'h02, 4'h0, 1'b0);
    check_latched(8'h01, 4'h0);
    clear_all(`LED_NORMAL);
    fire(8'h02, 4'h0, 1'b1);
    check_latched(8'h02, 4'h0);
    clear_all(`LED_NORMAL);
    // Second ROM fault must keep the index of the first one
    fire(8'h08, 4'h5, 1'b0);
    fire(8'h10, 4'hA, 1'b0);
    check_latched(8'h08, 4'h5);
    clear_all(`LED_NORMAL);
    $display("test fault codes done");
    off_try(999999);
    off_try(-999999);
    off_try(1000000);
    off_try(-1000000);
    repeat (10) off_try(int'($urandom_range(0, 4000000)) - 2000000);
    $display("test offset limit done");
    // Slave not ready shows only while no alarm is latched
    @(posedge mclk);
    slv <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("slave led", `LED_SLAVE_OFF, led);
    fire(8'h01, 4'h0, 1'b0);
    chk("alarm over slave", `LED_SYS_ALARM, led);
    clear_all(`LED_SLAVE_OFF);
    @(posedge mclk);
    slv <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("normal led", `LED_NORMAL, led);
    $display("test slave ready done");
    // Failing RAM number, sticky until clear
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      fail_t <= 1'b1;
      num <= i[2:0];
      @(posedge mclk);
      fail_t <= 1'b0;
      repeat (4) @(negedge mclk);
      chk("ram fail led", {1'b1, i[2:0]}, led);
      clear_all(`LED_NORMAL);
    end
    $display("test ram number done");
    // Flicker while the RAM test waits and after it ends
    for (int j = 0; j < 2; j++) begin
      on = 0;
      off = 0;
      other = 0;
      @(posedge mclk);
      wait_t <= (j == 0);
      end_t <= (j == 1);
      repeat (2) @(negedge mclk);
      repeat (24) begin
        @(negedge mclk);
        if (led === `LED_ALL_ON) on++;
        else if (led === `LED_NORMAL) off++;
        else other++;
      end
      chk("flicker shape", 32'h1, (on >= 8) && (off >= 8) && (other == 0));
      @(posedge mclk);
      {wait_t, end_t} <= 2'b00;
      repeat (2) @(negedge mclk);
      chk("flicker stop", `LED_NORMAL, led);
    end
    $display("test flicker done");
    stop_test();
  end
endmodule // system_alarm_indicator_test
